//--- ldip_pkg.sv
`default_nettype none

package ldip_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFFSET_SAMPLING_PHASE = 8'h0a;
    localparam logic [7:0] OFFSET_DATA_STATUS = 8'h0e;
    localparam logic [7:0] OFFSET_INPUT_CONFIG = 8'h26;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RESET_SAMPLING_PHASE = 8'h00;
    localparam logic [7:0] RESET_INPUT_CONFIG = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CFG_BYTE_MODE_BIT = 0;
    localparam int CFG_LANE_REVERSE_BIT = 5;
    localparam int CFG_PAIRING_BIT = 6;
    localparam int CFG_FORMAT_BIT = 7;
    localparam int PHASE_SIGN_BIT = 3;
    localparam int PHASE_MAG_MSB = 2;
    localparam int STATUS_RUNNING_BIT = 0;
    localparam int STATUS_CLOCK_VALID_BIT = 2;
    localparam int STATUS_OVERFLOW_BIT = 3;
    localparam int STATUS_LOCKED_BIT = 7;

    // ------------------------------------------------------------
    // phase arithmetic: quarter period is 8 sixteenths of a half
    // ------------------------------------------------------------
    localparam logic [4:0] PHASE_NOMINAL_SIXTEENTHS = 5'h08;
    localparam logic [3:0] PHASE_MAG_LIMIT = 4'h6;
    localparam logic [2:0] PHASE_MAG_ILLEGAL = 3'h7;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS = 8;
    localparam int REF_LOSS_NS = 2048;
    localparam int REF_LOSS_CYCLES = REF_LOSS_NS / CLOCK_PERIOD_NS;
    localparam int LOCK_EDGES = 8;
    localparam logic [7:0] HALF_TOLERANCE = 8'h01;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] inphase;
        logic [15:0] quadrature;
    } ldip_pair_type;

    localparam int PAIR_WIDTH = 32;
    localparam int FIFO_DEPTH = 16;

endpackage

`default_nettype wire

//--- ldip_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module ldip_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
            $error("fifo depth must be a power of two of at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // output stage refills whenever it is empty or being drained
    assign in_ready = (count != FULL_COUNT);
    assign push = in_valid && in_ready;
    assign pop = (count != '0) && (!out_valid || out_ready);

    // storage write
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // registered read keeps the output straight off a flop
    always_ff @(posedge clock) begin
        if (reset) begin
            out_data <= '0;
        end else if (pop) begin
            out_data <= mem[rd_ptr];
        end
    end

    // output valid
    always_ff @(posedge clock) begin
        if (reset) begin
            out_valid <= 1'b0;
        end else if (pop) begin
            out_valid <= 1'b1;
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

    // pointers and fill level
    always_ff @(posedge clock) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

//--- ldip_input_port.sv
`timescale 1ns/1ps
`default_nettype none

module ldip_input_port #(
    parameter int FIFO_DEPTH = ldip_pkg::FIFO_DEPTH,
    parameter int REF_LOSS_CYCLES = ldip_pkg::REF_LOSS_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic ref_clock_in,
    input wire logic [15:0] input_lanes,
    input wire logic frame_strobe,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_address,
    input wire logic [7:0] reg_write_data,
    output logic [7:0] reg_read_data,
    output logic pair_valid,
    input wire logic pair_ready,
    output ldip_pkg::ldip_pair_type pair_data
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    generate
        if (REF_LOSS_CYCLES < 16 || REF_LOSS_CYCLES > 65535) begin : g_bad
            $error("reference loss count out of range");
        end
    endgenerate

    localparam logic [15:0] LOSS_LIMIT = 16'(REF_LOSS_CYCLES);
    localparam logic [3:0] LOCK_LIMIT = 4'(ldip_pkg::LOCK_EDGES);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // cycles from a reference edge to the sampling point
    function automatic logic [7:0] sample_delay(input logic [7:0] half,
                                                input logic [3:0] offset);
        logic [3:0] mag;
        logic [4:0] mult;
        logic [12:0] prod;
        mag = {1'b0, offset[ldip_pkg::PHASE_MAG_MSB:0]};
        if (offset[ldip_pkg::PHASE_MAG_MSB:0] == ldip_pkg::PHASE_MAG_ILLEGAL) begin
            mag = ldip_pkg::PHASE_MAG_LIMIT; // clamp: magnitude must stay below 7
        end
        if (offset[ldip_pkg::PHASE_SIGN_BIT]) begin
            mult = ldip_pkg::PHASE_NOMINAL_SIXTEENTHS - {1'b0, mag};
        end else begin
            mult = ldip_pkg::PHASE_NOMINAL_SIXTEENTHS + {1'b0, mag};
        end
        prod = {5'h00, half} * {8'h00, mult};
        sample_delay = prod[11:4];
        if (sample_delay == 8'h00) begin
            sample_delay = 8'h01;
        end
    endfunction

    // offset binary becomes two's complement by flipping the msb
    function automatic logic [15:0] to_twos(input logic [15:0] word,
                                            input logic offset_binary);
        to_twos = {word[15] ^ offset_binary, word[14:0]};
    endfunction

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
    logic [15:0] lanes_s1;
    logic [15:0] lanes_s2;
    logic frame_s1;
    logic frame_s2;

    // data, frame and clock share the same depth so alignment survives
    always_ff @(posedge clock) begin
        if (reset) begin
            ref_s1 <= 1'b0;
            ref_s2 <= 1'b0;
            ref_s3 <= 1'b0;
            lanes_s1 <= 16'h0000;
            lanes_s2 <= 16'h0000;
            frame_s1 <= 1'b0;
            frame_s2 <= 1'b0;
        end else begin
            ref_s1 <= ref_clock_in;
            ref_s2 <= ref_s1;
            ref_s3 <= ref_s2;
            lanes_s1 <= input_lanes;
            lanes_s2 <= lanes_s1;
            frame_s1 <= frame_strobe;
            frame_s2 <= frame_s1;
        end
    end

    logic ref_edge;
    assign ref_edge = ref_s2 ^ ref_s3;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] sampling_phase_offset;
    logic [7:0] input_port_config;
    logic [7:0] data_status;
    logic overflow;
    logic set_overflow;
    logic clock_valid;
    logic locked;

    // software writes
    always_ff @(posedge clock) begin
        if (reset) begin
            sampling_phase_offset <= ldip_pkg::RESET_SAMPLING_PHASE;
            input_port_config <= ldip_pkg::RESET_INPUT_CONFIG;
        end else if (reg_write) begin
            if (reg_address == ldip_pkg::OFFSET_SAMPLING_PHASE) begin
                sampling_phase_offset <= reg_write_data;
            end
            if (reg_address == ldip_pkg::OFFSET_INPUT_CONFIG) begin
                input_port_config <= reg_write_data;
            end
        end
    end

    always_comb begin
        data_status = 8'h00;
        data_status[ldip_pkg::STATUS_RUNNING_BIT] = clock_valid;
        data_status[ldip_pkg::STATUS_CLOCK_VALID_BIT] = clock_valid;
        data_status[ldip_pkg::STATUS_OVERFLOW_BIT] = overflow;
        data_status[ldip_pkg::STATUS_LOCKED_BIT] = locked;
    end

    // read port, unmapped addresses answer zero
    always_ff @(posedge clock) begin
        if (reset) begin
            reg_read_data <= 8'h00;
        end else if (reg_read) begin
            unique case (reg_address)
                ldip_pkg::OFFSET_SAMPLING_PHASE: begin
                    reg_read_data <= sampling_phase_offset;
                end
                ldip_pkg::OFFSET_INPUT_CONFIG: begin
                    reg_read_data <= input_port_config;
                end
                ldip_pkg::OFFSET_DATA_STATUS: begin
                    reg_read_data <= data_status;
                end
                default: begin
                    reg_read_data <= 8'h00;
                end
            endcase
        end
    end

    // overflow is sticky, cleared by reading status; a new loss wins
    always_ff @(posedge clock) begin
        if (reset) begin
            overflow <= 1'b0;
        end else if (set_overflow) begin
            overflow <= 1'b1;
        end else if (reg_read && reg_address == ldip_pkg::OFFSET_DATA_STATUS) begin
            overflow <= 1'b0;
        end
    end

    logic byte_mode;
    logic lane_reverse;
    logic pair_late_q;
    logic offset_binary;
    assign byte_mode = input_port_config[ldip_pkg::CFG_BYTE_MODE_BIT];
    assign lane_reverse = input_port_config[ldip_pkg::CFG_LANE_REVERSE_BIT];
    assign pair_late_q = input_port_config[ldip_pkg::CFG_PAIRING_BIT];
    assign offset_binary = input_port_config[ldip_pkg::CFG_FORMAT_BIT];

    // ------------------------------------------------------------
    // delay loop: half-period measure, lock and loss detection
    // ------------------------------------------------------------
    logic [7:0] half_count;
    logic [7:0] half_period;
    logic [3:0] stable_edges;
    logic [15:0] loss_count;

    // the loop only sees whole system cycles; fine steps round down
    always_ff @(posedge clock) begin
        if (reset) begin
            half_count <= 8'h01;
            half_period <= 8'h00;
            stable_edges <= 4'h0;
        end else if (ref_edge) begin
            half_count <= 8'h01;
            half_period <= half_count;
            if ((half_count - half_period <= ldip_pkg::HALF_TOLERANCE) ||
                (half_period - half_count <= ldip_pkg::HALF_TOLERANCE)) begin
                if (stable_edges != LOCK_LIMIT) begin
                    stable_edges <= stable_edges + 4'h1;
                end
            end else begin
                stable_edges <= 4'h0;
            end
        end else if (half_count != 8'hff) begin
            half_count <= half_count + 8'h01;
        end
    end

    // a silent reference drops valid and lock
    always_ff @(posedge clock) begin
        if (reset) begin
            loss_count <= 16'h0000;
            clock_valid <= 1'b0;
        end else if (ref_edge) begin
            loss_count <= 16'h0000;
            clock_valid <= 1'b1;
        end else if (loss_count == LOSS_LIMIT) begin
            clock_valid <= 1'b0;
        end else begin
            loss_count <= loss_count + 16'h0001;
        end
    end

    assign locked = clock_valid && (stable_edges == LOCK_LIMIT);

    // ------------------------------------------------------------
    // sampling points on both reference edges
    // ------------------------------------------------------------
    logic [7:0] sample_wait;
    logic sample_after_rise;
    logic sample_fire;

    // shifted sample point after each edge while locked
    always_ff @(posedge clock) begin
        if (reset) begin
            sample_wait <= 8'h00;
            sample_after_rise <= 1'b0;
        end else if (ref_edge && locked) begin
            sample_wait <= sample_delay(half_period, sampling_phase_offset[3:0]);
            sample_after_rise <= ref_s2;
        end else if (sample_wait != 8'h00) begin
            sample_wait <= sample_wait - 8'h01;
        end
    end

    assign sample_fire = (sample_wait == 8'h01);

    // lane reversal; byte mode uses lower lanes only
    logic [15:0] word_in;
    logic [7:0] byte_in;
    always_comb begin
        word_in = lanes_s2;
        byte_in = lanes_s2[7:0];
        if (lane_reverse) begin
            for (int k = 0; k < 16; k++) begin
                word_in[k] = lanes_s2[15-k];
            end
            for (int k = 0; k < 8; k++) begin
                byte_in[k] = lanes_s2[7-k];
            end
        end
    end

    // ------------------------------------------------------------
    // assembly
    // ------------------------------------------------------------
    logic [15:0] held_word;
    logic held_ok;
    logic [23:0] held_bytes;
    logic [1:0] byte_index;
    logic aligned;
    logic frame_last;
    logic frame_rise;
    logic emit;
    ldip_pkg::ldip_pair_type emit_pair;

    // frame strobe taken at the same points as data
    assign frame_rise = sample_fire && frame_s2 && !frame_last;

    always_ff @(posedge clock) begin
        if (reset) begin
            frame_last <= 1'b0;
        end else if (sample_fire) begin
            frame_last <= frame_s2;
        end
    end

    // emit a pair when the closing half of a word pair or byte quad lands
    always_comb begin
        emit = 1'b0;
        emit_pair.inphase = held_word;
        emit_pair.quadrature = word_in;
        if (sample_fire && !byte_mode && held_ok) begin
            // first word of the pair selects the edge
            if (!pair_late_q && !sample_after_rise) begin
                emit = 1'b1;
            end else if (pair_late_q && sample_after_rise) begin
                emit = 1'b1;
                emit_pair.inphase = word_in;
                emit_pair.quadrature = held_word;
            end
        end else if (sample_fire && byte_mode && aligned && !frame_rise &&
                     byte_index == 2'h3) begin
            emit = 1'b1;
            emit_pair.inphase = held_bytes[23:8];
            emit_pair.quadrature = {held_bytes[7:0], byte_in};
        end
        emit_pair.inphase = to_twos(emit_pair.inphase, offset_binary);
        emit_pair.quadrature = to_twos(emit_pair.quadrature, offset_binary);
    end

    // word mode holds the opening word of each pair
    always_ff @(posedge clock) begin
        if (reset || reg_write) begin
            held_word <= 16'h0000;
            held_ok <= 1'b0;
        end else if (sample_fire && !byte_mode) begin
            if (sample_after_rise != pair_late_q) begin
                held_word <= word_in;
                held_ok <= 1'b1;
            end
        end
    end

    // frame rising edge restarts byte count; alignment persists until reset or any register write
    always_ff @(posedge clock) begin
        if (reset || reg_write) begin
            byte_index <= 2'h0;
            aligned <= 1'b0;
            held_bytes <= 24'h000000;
        end else if (sample_fire && byte_mode) begin
            if (frame_rise) begin
                held_bytes <= {byte_in, 16'h0000};
                byte_index <= 2'h1;
                aligned <= 1'b1;
            end else if (aligned) begin
                unique case (byte_index)
                    2'h0: held_bytes[23:16] <= byte_in;
                    2'h1: held_bytes[15:8] <= byte_in;
                    2'h2: held_bytes[7:0] <= byte_in;
                    2'h3: held_bytes <= held_bytes;
                endcase
                byte_index <= byte_index + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // staging and buffer
    // ------------------------------------------------------------
    logic stage_valid;
    logic stage_ready;
    ldip_pkg::ldip_pair_type stage_pair;

    // the link cannot stall, so a pair that meets a full buffer is lost
    always_ff @(posedge clock) begin
        if (reset) begin
            stage_valid <= 1'b0;
            stage_pair <= '0;
        end else if (emit) begin
            stage_valid <= 1'b1;
            stage_pair <= emit_pair;
        end else if (stage_ready) begin
            stage_valid <= 1'b0;
        end
    end

    assign set_overflow = emit && stage_valid && !stage_ready;

    ldip_fifo #(
        .WIDTH(ldip_pkg::PAIR_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) pair_buffer (
        .clock(clock),
        .reset(reset),
        .in_valid(stage_valid),
        .in_ready(stage_ready),
        .in_data(stage_pair),
        .out_valid(pair_valid),
        .out_ready(pair_ready),
        .out_data(pair_data)
    );

endmodule

`default_nettype wire

//--- ldip_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module ldip_monitor #(
    parameter int REF_LOSS_CYCLES = 256
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic ref_clock_in,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_address,
    input wire logic [7:0] reg_write_data,
    input wire logic [7:0] reg_read_data,
    input wire logic pair_valid,
    input wire logic pair_ready,
    input wire ldip_pkg::ldip_pair_type pair_data
);
    logic ref_last;
    int quiet;
    wire rd_status = reg_read && reg_address == 8'h0e;

    // quiet cycles of the raw reference; sync flops need slack later
    always_ff @(posedge clock) begin
        ref_last <= ref_clock_in;
        if (reset || ref_clock_in != ref_last) begin
            quiet <= 0;
        end else if (quiet < 4096) begin
            quiet <= quiet + 1;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // register port and stream port relations
    reset_clear_a: assert property (disable iff (1'b0)
        reset |=> !pair_valid && reg_read_data == 8'h00)
        else $error("outputs not cleared by reset");
    start_quiet_a: assert property ($fell(reset) |-> !pair_valid [*8])
        else $error("pair offered before lock");
    pair_hold_a: assert property (pair_valid && !pair_ready |=>
        pair_valid && $stable(pair_data))
        else $error("pair dropped or changed while stalled");
    read_hold_a: assert property (!reg_read |=>
        $stable(reg_read_data))
        else $error("read data changed without a read");
    unmapped_zero_a: assert property (reg_read &&
        !(reg_address inside {8'h0a, 8'h0e, 8'h26}) |=>
        reg_read_data == 8'h00)
        else $error("unmapped read not zero");
    status_bits_a: assert property (rd_status |=>
        reg_read_data[6:4] == 3'h0 && reg_read_data[0] == reg_read_data[2])
        else $error("status bits malformed");
    lost_lock_a: assert property (rd_status &&
        quiet > REF_LOSS_CYCLES + 8 |=>
        reg_read_data[7] == 1'b0 && reg_read_data[2] == 1'b0)
        else $error("lock kept without reference");
    phase_back_a: assert property (reg_write &&
        reg_address == 8'h0a ##1 reg_read && reg_address == 8'h0a |=>
        reg_read_data == $past(reg_write_data, 2))
        else $error("phase offset read back wrong");

    cover property (pair_valid && pair_ready);
    cover property (pair_valid && !pair_ready);
    cover property (rd_status ##1 reg_read_data[7]);
endmodule

bind ldip_input_port ldip_monitor #(.REF_LOSS_CYCLES(REF_LOSS_CYCLES))
    u_ldip_monitor (.clock(clock), .reset(reset),
    .ref_clock_in(ref_clock_in), .reg_write(reg_write),
    .reg_read(reg_read), .reg_address(reg_address),
    .reg_write_data(reg_write_data), .reg_read_data(reg_read_data),
    .pair_valid(pair_valid), .pair_ready(pair_ready),
    .pair_data(pair_data));

`default_nettype wire

//--- ldip_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module ldip_host_model (
    input wire logic run,
    input wire logic byte_mode,
    input wire logic [15:0] inphase,
    input wire logic [15:0] quadrature,
    output logic ref_clock_in,
    output logic [15:0] input_lanes,
    output logic frame_strobe
);
    logic [15:0] w;
    int n = 0;

    // 64 ns reference, offset so its edges sit at a fixed point off the system grid
    initial begin
        ref_clock_in = 1'b0;
        input_lanes = 16'h0000;
        frame_strobe = 1'b0;
        #3;
        forever begin
            #32;
            if (run) begin
                ref_clock_in = !ref_clock_in;
                w = (byte_mode ? n[1] : !ref_clock_in) ? quadrature : inphase;
                if (byte_mode) begin
                    w = n[0] ? {~w[7:0], w[7:0]} : {~w[15:8], w[15:8]};
                    frame_strobe = !n[1];
                    n = (n + 1) % 4;
                end
                input_lanes = w;
            end else begin
                // parked clock: lanes keep moving so stale data is wrong
                input_lanes = ~input_lanes;
                frame_strobe = 1'b0;
                n = 0;
            end
        end
    end
endmodule

`default_nettype wire

//--- tb_ldip_input_port.sv
`timescale 1ns/1ps
`default_nettype none

module tb_ldip_input_port;
    logic clock, ref_clock_in, frame_strobe, pair_valid;
    logic reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    logic pair_ready = 1'b0, run = 1'b0, byte_mode = 1'b0;
    logic [7:0] reg_address = 8'h00, reg_write_data = 8'h00;
    logic [7:0] reg_read_data;
    logic [15:0] input_lanes, i, q;
    logic [15:0] ival = 16'h12c6, qval = 16'habc5;
    ldip_pkg::ldip_pair_type pair_data;
    int err_count = 0, n_checks = 0, cycles = 0, k;
    logic [15:0] tbl [9] = '{16'h0000, 16'h0080, 16'h0020, 16'h0040,
        16'h0600, 16'h0e00, 16'h0700, 16'h0001, 16'h0021};

    ldip_input_port #(.FIFO_DEPTH(16), .REF_LOSS_CYCLES(32))
        u_ldip_input_port (.clock(clock), .reset(reset),
        .ref_clock_in(ref_clock_in), .input_lanes(input_lanes),
        .frame_strobe(frame_strobe), .reg_write(reg_write),
        .reg_read(reg_read), .reg_address(reg_address),
        .reg_write_data(reg_write_data), .reg_read_data(reg_read_data),
        .pair_valid(pair_valid), .pair_ready(pair_ready),
        .pair_data(pair_data));
    ldip_host_model u_ldip_host_model (.run(run), .byte_mode(byte_mode),
        .inphase(ival), .quadrature(qval), .ref_clock_in(ref_clock_in),
        .input_lanes(input_lanes), .frame_strobe(frame_strobe));

    // system clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // hang guard: the whole run needs well under this
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_address <= a;
        reg_write_data <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    // read data stands after the read, so it is taken one edge later
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_address <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(posedge clock);
        check("register", reg_read_data, exp);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        pair_ready <= 1'b1;
        // defaults, read back and refused places
        rd(8'h0a, 8'h00);
        rd(8'h26, 8'h00);
        wr(8'h0a, 8'ha5);
        rd(8'h0a, 8'ha5);
        wr(8'h0e, 8'hff);
        rd(8'h0e, 8'h00);
        rd(8'h55, 8'h00);
        $display("test registers done");
        // lock: first pair only once the loop has settled
        run <= 1'b1;
        k = 0;
        while (pair_valid !== 1'b1 && k < 2000) begin
            @(posedge clock);
            k++;
        end
        check("lock", pair_valid, 32'h1);
        rd(8'h0e, 8'h85);
        $display("test lock done");
        // capture across format, lane order, phase and byte mode
        foreach (tbl[t]) begin
            byte_mode <= tbl[t][0];
            wr(8'h0a, tbl[t][15:8]);
            // let an edge pass so the write strobe is not set twice at once
            @(posedge clock);
            wr(8'h26, tbl[t][7:0]);
            i = ival;
            q = qval;
            if (tbl[t][5]) begin
                i = {<<{i}};
                q = {<<{q}};
            end
            if (tbl[t][5] && tbl[t][0]) begin
                i = {<<8{i}};
                q = {<<8{q}};
            end
            i[15] ^= tbl[t][7];
            q[15] ^= tbl[t][7];
            repeat (120) @(posedge clock);
            k = 0;
            while (pair_valid !== 1'b1 && k < 200) begin
                @(posedge clock);
                k++;
            end
            check("valid", pair_valid, 32'h1);
            check("pair", pair_data, {i, q});
        end
        $display("test capture done");
        // stall until the buffer overflows, then drain it empty
        pair_ready <= 1'b0;
        repeat (400) @(posedge clock);
        run <= 1'b0;
        repeat (100) @(posedge clock);
        check("held valid", pair_valid, 32'h1);
        check("held", pair_data, {i, q});
        rd(8'h0e, 8'h08);
        rd(8'h0e, 8'h00);
        pair_ready <= 1'b1;
        k = 0;
        repeat (40) @(posedge clock) k += pair_valid;
        // buffer words plus the output flop plus the staged pair
        check("drained", k, 32'(ldip_pkg::FIFO_DEPTH + 2));
        $display("test buffer done");
        results();
    end
endmodule

`default_nettype wire
